// ===== src/rlb_consts.svh
/*
  constants for the rgb led pwm blink driver: register addresses,
  config bit positions, clock rate and pwm timing counts.
  assumes a single 40 MHz clock shared by control bus and pwm logic.
*/
`ifndef RLB_CONSTS_SVH
`define RLB_CONSTS_SVH

// register addresses on the 4-bit control bus
`define RLB_ADDR_CFG   4'h0
`define RLB_ADDR_RAMP  4'h1
`define RLB_ADDR_ON    4'h2
`define RLB_ADDR_OFF   4'h3
`define RLB_ADDR_RED   4'h4
`define RLB_ADDR_GRN   4'h5
`define RLB_ADDR_BLU   4'h6

// config register bit positions
`define RLB_CFG_FAST   0
`define RLB_CFG_INV    1
`define RLB_CFG_SKEW   2
`define RLB_CFG_LFSR   3
`define RLB_CFG_BON    4
`define RLB_CFG_BOFF   5

// clock and flick rates in hertz
`define RLB_CLK_HZ     40000000
`define RLB_SLOW_HZ    125
`define RLB_FAST_HZ    250
`define RLB_LEVELS     256

// clocks per pwm step, derived from the rates above
`define RLB_STEP_SLOW  (`RLB_CLK_HZ / (`RLB_SLOW_HZ * `RLB_LEVELS))
`define RLB_STEP_FAST  (`RLB_CLK_HZ / (`RLB_FAST_HZ * `RLB_LEVELS))

// one blink time unit is eight pwm frames
`define RLB_UNIT_PAD   3'h0

// misc values
`define RLB_FULL       8'hff
`define RLB_ZERO       8'h00
`define RLB_ONE        8'h01
`define RLB_SKEW_STEP  8'h55
`define RLB_LFSR_TAPS  8'hb8

`endif

// ===== src/rlb_pkg.sv
/*
  types for the rgb led pwm blink driver: blink states and the packed
  state records of the core and of one pwm channel.
  assumes the constants header is compiled alongside.
*/
package rlb_pkg;

  // blink sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ON   = 2'b01,
    ST_OFF  = 2'b10
  } rlb_state_t;

  // whole state of the core
  typedef struct packed {
    logic [7:0]      cfg;       // mode bits
    logic [7:0]      ramp;      // ramp rate, low nibble used
    logic [7:0]      onTime;    // on period in units of 8 frames
    logic [7:0]      offTime;   // off period in units of 8 frames
    logic [2:0][7:0] duty;      // red, green, blue brightness
    logic [10:0]     presc;     // clocks within one pwm step
    logic [7:0]      pwmCnt;    // linear phase counter
    logic [7:0]      lfsr;      // pseudo-random phase
    logic [10:0]     frameCnt;  // frames in current blink state
    logic [3:0]      rampCnt;   // frames since last ramp step
    logic [7:0]      scale;     // breathe brightness scale
    rlb_state_t      state;     // blink state
    logic            lit;       // led lit flag
  } rlb_core_t;

  // state of one pwm channel
  typedef struct packed {
    logic pwm;
  } rlb_chan_st_t;

endpackage

// ===== src/rlb_chan_if.sv
/*
  interface between the core and one pwm channel comparator.
  assumes both ends run on the same clock.
*/
interface rlb_chan_if;
  logic [7:0] phase;   // shared counter or lfsr phase
  logic [7:0] duty;    // effective duty after breathe scaling
  logic       invert;  // output polarity inversion
  logic       skewEn;  // apply channel phase offset
  logic       active;  // led lit, pwm allowed
  logic       pwm;     // registered pwm level

  modport drv  (output phase, duty, invert, skewEn, active, input pwm);
  modport chan (input phase, duty, invert, skewEn, active, output pwm);
endinterface

// ===== src/rlb_pwm_chan.sv
/*
  one pwm channel: compares the skewed phase with the duty and
  registers the output level with optional inversion.
  assumes phase advances once per pwm step in the core.
*/
`include "rlb_consts.svh"
module rlb_pwm_chan
  import rlb_pkg::*;
#(
  parameter logic [7:0] SKEW = 8'h00  // phase offset of this channel
) (
  // clock and reset
  input wire logic  clk,
  input wire logic  srst,
  // link to core
  rlb_chan_if.chan  bus
);

  rlb_chan_st_t st_reg;   // registered state
  rlb_chan_st_t st_next;  // next state
  logic [7:0]   skewed;   // phase after offset

  // compare and polarity; offset spreads edges across channels
  always_comb begin
    st_next = st_reg;
    skewed  = bus.phase + (bus.skewEn ? SKEW : `RLB_ZERO);
    st_next.pwm = (bus.active && (skewed < bus.duty)) ^ bus.invert;
    if (srst) begin
      st_next = '0;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign bus.pwm = st_reg.pwm;

  a_off_level: assert property (@(posedge clk) disable iff (srst)
    !bus.active |=> bus.pwm == $past(bus.invert))
    else $error("dark channel not at idle level");

  a_zero_duty: assert property (@(posedge clk) disable iff (srst)
    (bus.active && bus.duty == `RLB_ZERO) |=> bus.pwm == $past(bus.invert))
    else $error("zero duty produced a pulse");

endmodule

// ===== src/rlb_led_pwm.sv
/*
  rgb led pwm blink driver core: write-only control bus, register
  bank, step divider, phase generators, blink sequencer with breathe
  ramps, and three pwm channels.
  assumes a 40 MHz clock and bus inputs synchronous to it.
*/
`include "rlb_consts.svh"

module rlb_led_pwm
  import rlb_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // control bus, write only
  input  wire logic        ctrlSelect,
  input  wire logic        ctrlDataValid,
  input  wire logic [3:0]  ctrlRegAddr,
  input  wire logic [7:0]  ctrlWriteData,
  // sequence control
  input  wire logic        blinkRun,
  // led outputs
  output logic             pwmRedOut,
  output logic             pwmGreenOut,
  output logic             pwmBlueOut,
  output logic             ledLitFlag
);

  rlb_core_t   st_reg;      // registered state
  rlb_core_t   st_next;     // next state
  logic [10:0] stepLimit;   // last presc value of a step
  logic        stepTick;    // one pwm step elapsed
  logic        frameTick;   // one pwm frame elapsed
  logic        rampStep;    // breathe scale moves this frame
  logic        breatheOn;   // ramp up at turn-on
  logic        breatheOff;  // ramp down at turn-off
  logic [10:0] onLen;       // on period in frames
  logic [10:0] offLen;      // off period in frames
  logic [7:0]  phase;       // phase fed to channels

  rlb_chan_if chanIf [3] ();

  // divider rate select; the step count sets the flick rate
  always_comb begin
    stepLimit = st_reg.cfg[`RLB_CFG_FAST] ? 11'(`RLB_STEP_FAST - 1)
                                          : 11'(`RLB_STEP_SLOW - 1);
    stepTick  = st_reg.presc == stepLimit;
    frameTick = stepTick && (st_reg.pwmCnt == `RLB_FULL);
    rampStep  = frameTick && (st_reg.rampCnt == st_reg.ramp[3:0]);
    breatheOn  = st_reg.cfg[`RLB_CFG_BON];
    breatheOff = st_reg.cfg[`RLB_CFG_BOFF];
    onLen  = {st_reg.onTime, `RLB_UNIT_PAD};
    offLen = {st_reg.offTime, `RLB_UNIT_PAD};
  end

  // next state: bus writes, timing, blink sequencer, reset
  always_comb begin
    st_next = st_reg;

    // write strobe needs both select and enable; no read path
    if (ctrlSelect && ctrlDataValid) begin
      case (ctrlRegAddr)
        `RLB_ADDR_CFG:  st_next.cfg     = ctrlWriteData;
        `RLB_ADDR_RAMP: st_next.ramp    = ctrlWriteData;
        `RLB_ADDR_ON:   st_next.onTime  = ctrlWriteData;
        `RLB_ADDR_OFF:  st_next.offTime = ctrlWriteData;
        `RLB_ADDR_RED:  st_next.duty[0] = ctrlWriteData;
        `RLB_ADDR_GRN:  st_next.duty[1] = ctrlWriteData;
        `RLB_ADDR_BLU:  st_next.duty[2] = ctrlWriteData;
        default: ;  // unused addresses are dropped
      endcase
    end

    // step divider runs free in every state; only a config write or reset restarts it
    st_next.presc = stepTick ? '0 : st_reg.presc + 11'h001;
    // a config write may shorten the step; restart it so presc never
    // overshoots the new limit and runs on to wrap-around
    if (ctrlSelect && ctrlDataValid && ctrlRegAddr == `RLB_ADDR_CFG) begin
      st_next.presc = '0;
    end
    if (stepTick) begin
      st_next.pwmCnt = st_reg.pwmCnt + `RLB_ONE;
      // xnor feedback, so the cleared value is a legal state
      st_next.lfsr = {st_reg.lfsr[6:0], ~^(st_reg.lfsr & `RLB_LFSR_TAPS)};
    end
    if (frameTick) begin
      st_next.rampCnt  = rampStep ? '0 : st_reg.rampCnt + 4'h1;
      st_next.frameCnt = st_reg.frameCnt + 11'h001;
    end

    // blink sequencer
    case (st_reg.state)
      ST_IDLE: begin
        st_next.scale    = `RLB_ZERO;
        st_next.frameCnt = '0;
        st_next.rampCnt  = '0;
        if (blinkRun) begin
          st_next.state = ST_ON;
          st_next.scale = breatheOn ? `RLB_ZERO : `RLB_FULL;
        end
      end
      ST_ON: begin
        // without breathe the led is at full scale at once
        if (!breatheOn) begin
          st_next.scale = `RLB_FULL;
        end else if (rampStep && st_reg.scale != `RLB_FULL) begin
          st_next.scale = st_reg.scale + `RLB_ONE;
        end
        if (frameTick && st_reg.frameCnt >= onLen) begin
          st_next.frameCnt = '0;
          st_next.rampCnt  = '0;
          if (blinkRun) begin
            st_next.state = ST_OFF;
            st_next.scale = breatheOff ? st_reg.scale : `RLB_ZERO;
          end else begin
            // run dropped: finish here rather than start another off
            st_next.state = ST_IDLE;
            st_next.scale = `RLB_ZERO;
          end
        end
      end
      ST_OFF: begin
        if (!blinkRun) begin
          st_next.state = ST_IDLE;
          st_next.scale = `RLB_ZERO;
        end else begin
          if (!breatheOff) begin
            st_next.scale = `RLB_ZERO;
          end else if (rampStep && st_reg.scale != `RLB_ZERO) begin
            st_next.scale = st_reg.scale - `RLB_ONE;
          end
          if (frameTick && st_reg.frameCnt >= offLen) begin
            st_next.state    = ST_ON;
            st_next.frameCnt = '0;
            st_next.rampCnt  = '0;
            st_next.scale    = breatheOn ? `RLB_ZERO : `RLB_FULL;
          end
        end
      end
      default: begin
        st_next.state = ST_IDLE;  // recover from illegal code
      end
    endcase

    // lit flag follows the next state so it stays registered
    st_next.lit = (st_next.state == ST_ON) || (st_next.scale != `RLB_ZERO);

    if (srst) begin
      st_next = '0;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  // phase source: square pulses or spread spectrum
  assign phase = st_reg.cfg[`RLB_CFG_LFSR] ? st_reg.lfsr : st_reg.pwmCnt;

  // per channel drive and comparator instances
  for (genvar i = 0; i < 3; i++) begin : gChan
    // scaling by scale+1 keeps full scale equal to the raw duty
    assign chanIf[i].duty = 8'((16'(st_reg.duty[i]) * 16'(st_reg.scale)
                               + 16'(st_reg.duty[i])) >> 8);
    assign chanIf[i].phase  = phase;
    assign chanIf[i].invert = st_reg.cfg[`RLB_CFG_INV];
    assign chanIf[i].skewEn = st_reg.cfg[`RLB_CFG_SKEW];
    assign chanIf[i].active = st_reg.lit;
    rlb_pwm_chan #(
      .SKEW (8'(i * `RLB_SKEW_STEP))
    ) rlb_pwm_chan_inst (
      .clk  (clk),
      .srst (srst),
      .bus  (chanIf[i])
    );
  end

  // outputs come straight from channel and core flip-flops
  assign pwmRedOut   = chanIf[0].pwm;
  assign pwmGreenOut = chanIf[1].pwm;
  assign pwmBlueOut  = chanIf[2].pwm;
  assign ledLitFlag  = st_reg.lit;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence sIdleRun;
    (st_reg.state == ST_IDLE) && blinkRun;
  endsequence

  sequence sOffDrop;
    (st_reg.state == ST_OFF) && !blinkRun;
  endsequence

  a_write_store: assert property (
    (ctrlSelect && ctrlDataValid && ctrlRegAddr == `RLB_ADDR_RED)
      |=> st_reg.duty[0] == $past(ctrlWriteData))
    else $error("red duty write not stored");

  a_cs_ignore: assert property (
    !ctrlSelect |=> (st_reg.duty == $past(st_reg.duty)) && $stable(st_reg.cfg))
    else $error("bus acted on without select");

  a_den_ignore: assert property (
    !ctrlDataValid |=> $stable(st_reg.onTime) && $stable(st_reg.offTime))
    else $error("bus acted on without data enable");

  a_reset_clear: assert property (disable iff (1'b0)
    srst |=> st_reg == '0 && !ledLitFlag && !pwmRedOut)
    else $error("reset left state behind");

  a_step_bound: assert property (
    st_reg.presc <= stepLimit)
    else $error("step divider out of range");

  a_step_wrap: assert property (
    stepTick |=> st_reg.presc == '0)
    else $error("step divider did not wrap");

  a_run_start: assert property (
    sIdleRun |=> (st_reg.state == ST_ON) ##0 ledLitFlag)
    else $error("run did not start the sequence");

  a_stop_at_off: assert property (
    sOffDrop |=> (st_reg.state == ST_IDLE) && !ledLitFlag)
    else $error("sequence did not stop at off");

  a_on_lit: assert property (
    (st_reg.state == ST_ON) |-> ledLitFlag)
    else $error("lit flag low while on");

  a_no_breathe: assert property (
    (st_reg.state == ST_ON && !breatheOn && !frameTick) |=> st_reg.scale == `RLB_FULL)
    else $error("full scale missing without breathe");

  a_phase_mode: assert property (
    stepTick && !st_reg.cfg[`RLB_CFG_LFSR] && !(ctrlSelect && ctrlDataValid)
      |=> phase == $past(st_reg.pwmCnt) + `RLB_ONE)
    else $error("linear phase did not advance");

endmodule

// ===== bench/rlb_fabric_model.sv
/*
  fabric-side model of the controlling logic: presents one byte at a
  time on the write-only control bus, launched on the falling edge.
  assumes the block samples the bus on the rising edge of clk.
*/
module rlb_fabric_model (
  // clock
  input  wire logic       clk,
  // control bus towards the block
  output logic            ctrlSelect,
  output logic            ctrlDataValid,
  output logic [3:0]      ctrlRegAddr,
  output logic [7:0]      ctrlWriteData
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle from time zero so no unknown reaches the block
  initial begin
    ctrlSelect    = 1'b0;
    ctrlDataValid = 1'b0;
    ctrlRegAddr   = 4'hf;
    ctrlWriteData = 8'h5a;
  end

  // one write cycle; sel or valid low presents a cycle the block must drop
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data,
                           input logic sel, input logic valid);
    @(negedge clk);
    ctrlRegAddr   = addr;
    ctrlWriteData = data;
    ctrlSelect    = sel;
    ctrlDataValid = valid;
    // held unchanged across exactly one rising edge
    @(negedge clk);
    ctrlSelect    = 1'b0;
    ctrlDataValid = 1'b0;
    // released lines flip so a stale byte can never pass for a fresh one
    ctrlRegAddr   = ~addr;
    ctrlWriteData = ~data;
  endtask
endmodule

// ===== bench/rlb_led_pwm_bench.sv
/*
  self-checking bench for the rgb led pwm blink driver core.
  assumes a 40 MHz clock; full pwm frames are far too long to simulate,
  so only the first steps of a frame are judged.
*/
`include "rlb_consts.svh"

module rlb_led_pwm_bench
  import rlb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;            // 40 MHz system clock
  logic       srst;           // synchronous reset
  logic       blinkRun;       // sequence run level
  logic       ctrlSelect;     // bus from the fabric model
  logic       ctrlDataValid;
  logic [3:0] ctrlRegAddr;
  logic [7:0] ctrlWriteData;
  logic       pwmRedOut;      // block outputs
  logic       pwmGreenOut;
  logic       pwmBlueOut;
  logic       ledLitFlag;
  int         nFail;          // mismatches seen
  int         nTests;         // comparisons made

  rlb_fabric_model fabric_inst (
    .clk(clk), .ctrlSelect(ctrlSelect), .ctrlDataValid(ctrlDataValid),
    .ctrlRegAddr(ctrlRegAddr), .ctrlWriteData(ctrlWriteData)
  );

  rlb_led_pwm rlb_led_pwm_inst (
    .clk(clk), .srst(srst), .ctrlSelect(ctrlSelect), .ctrlDataValid(ctrlDataValid),
    .ctrlRegAddr(ctrlRegAddr), .ctrlWriteData(ctrlWriteData), .blinkRun(blinkRun),
    .pwmRedOut(pwmRedOut), .pwmGreenOut(pwmGreenOut), .pwmBlueOut(pwmBlueOut),
    .ledLitFlag(ledLitFlag)
  );

  // clock generator, 25 ns period
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // single bit compare; case equality so an unknown never matches
  task automatic checkBit(input logic got, input logic exp, input string what);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // all four outputs at once
  task automatic checkOuts(input logic r, input logic g, input logic b,
                           input logic lit, input string what);
    checkBit(pwmRedOut, r, what);
    checkBit(pwmGreenOut, g, what);
    checkBit(pwmBlueOut, b, what);
    checkBit(ledLitFlag, lit, what);
  endtask

  task automatic waitCycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // counts level changes of the red output over n cycles
  task automatic countToggles(input int n, output int cnt);
    logic last;
    cnt  = 0;
    last = pwmRedOut;
    repeat (n) begin
      @(negedge clk);
      if (pwmRedOut !== last) cnt++;
      last = pwmRedOut;
    end
  endtask

  // dropped cycles change nothing, then a real write flips polarity
  task automatic testIgnore();
    fabric_inst.write_reg(`RLB_ADDR_CFG, 8'h02, 1'b0, 1'b1);
    fabric_inst.write_reg(`RLB_ADDR_CFG, 8'h02, 1'b1, 1'b0);
    fabric_inst.write_reg(4'h7, 8'h02, 1'b1, 1'b1);
    waitCycles(2);
    checkOuts(1'b0, 1'b0, 1'b0, 1'b0, "dropped write changed outputs");
    fabric_inst.write_reg(`RLB_ADDR_CFG, 8'h02, 1'b1, 1'b1);
    waitCycles(2);
    checkOuts(1'b1, 1'b1, 1'b1, 1'b0, "idle level not inverted");
    $display("test ignore done");
  endtask

  // levels near the start of a frame, then channel skew
  task automatic testPwm();
    fabric_inst.write_reg(`RLB_ADDR_CFG, 8'h01, 1'b1, 1'b1);
    fabric_inst.write_reg(`RLB_ADDR_RED, 8'hff, 1'b1, 1'b1);
    fabric_inst.write_reg(`RLB_ADDR_GRN, 8'h00, 1'b1, 1'b1);
    fabric_inst.write_reg(`RLB_ADDR_BLU, 8'h80, 1'b1, 1'b1);
    blinkRun = 1'b1;
    @(negedge clk);
    checkBit(ledLitFlag, 1'b1, "lit flag late");
    waitCycles(3);
    checkOuts(1'b1, 1'b0, 1'b1, 1'b1, "duty levels");
    fabric_inst.write_reg(`RLB_ADDR_GRN, 8'h80, 1'b1, 1'b1);
    fabric_inst.write_reg(`RLB_ADDR_CFG, 8'h05, 1'b1, 1'b1);
    waitCycles(3);
    checkOuts(1'b1, 1'b1, 1'b0, 1'b1, "skewed levels");
    $display("test pwm done");
  endtask

  // linear phase crawls past no edge in 20 steps, the lfsr jumps about
  task automatic testLfsr();
    int cnt;
    fabric_inst.write_reg(`RLB_ADDR_RED, 8'h80, 1'b1, 1'b1);
    fabric_inst.write_reg(`RLB_ADDR_CFG, 8'h01, 1'b1, 1'b1);
    countToggles(20 * `RLB_STEP_FAST, cnt);
    checkBit(cnt == 0, 1'b1, "counter mode toggled");
    fabric_inst.write_reg(`RLB_ADDR_CFG, 8'h09, 1'b1, 1'b1);
    countToggles(20 * `RLB_STEP_FAST, cnt);
    checkBit(cnt >= 3, 1'b1, "lfsr mode too regular");
    fabric_inst.write_reg(`RLB_ADDR_CFG, 8'h01, 1'b1, 1'b1);
    $display("test lfsr done");
  endtask

  // run falling in the on period must not darken the led at once
  task automatic testStop();
    blinkRun = 1'b0;
    waitCycles(8);
    checkBit(ledLitFlag, 1'b1, "stopped before off state");
    $display("test stop done");
  endtask

  // reset in mid-run clears state, config included
  task automatic testReset();
    srst = 1'b1;
    waitCycles(3);
    checkOuts(1'b0, 1'b0, 1'b0, 1'b0, "outputs during reset");
    srst = 1'b0;
    waitCycles(2);
    checkOuts(1'b0, 1'b0, 1'b0, 1'b0, "outputs after reset");
    $display("test reset done");
  endtask

  // breathe on starts dark although lit is already flagged
  task automatic testBreathe();
    fabric_inst.write_reg(`RLB_ADDR_RAMP, 8'h0f, 1'b1, 1'b1);
    fabric_inst.write_reg(`RLB_ADDR_RED, 8'hff, 1'b1, 1'b1);
    fabric_inst.write_reg(`RLB_ADDR_CFG, 8'h11, 1'b1, 1'b1);
    blinkRun = 1'b1;
    @(negedge clk);
    checkBit(ledLitFlag, 1'b1, "lit flag late");
    waitCycles(20);
    checkBit(pwmRedOut, 1'b0, "breathe ramp not dark");
    $display("test breathe done");
  endtask

  // verdict and end of run
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog, well over twice the expected run length
  initial begin
    #(60000 * 25);
    nFail++;
    $display("wrong value at %0t: watchdog expired", $time);
    stopTest();
  end

  // main sequence
  initial begin
    nFail    = 0;
    nTests   = 0;
    srst     = 1'b1;
    blinkRun = 1'b0;
    waitCycles(3);
    srst = 1'b0;
    testIgnore();
    testPwm();
    testLfsr();
    testStop();
    testReset();
    testBreathe();
    stopTest();
  end
endmodule
